// ===== hw/emb_pkg.sv
`default_nettype none
package emb_pkg;
  localparam int unsigned DATA_W   = 18;
  localparam int unsigned ADDR_W   = 13;
  localparam int unsigned IDX_W    = 14;
  localparam int unsigned BITS     = 9216;
  localparam int unsigned ROWS     = 512;
  localparam int unsigned ROW_AW   = 9;
  localparam int unsigned FLASH_AW = 12;
  localparam int unsigned BUS_AW   = 4;
  localparam int unsigned BUS_DW   = 32;
  localparam int unsigned WCODE_W  = 3;

  typedef enum logic [1:0] {
    EMB_SINGLE      = 2'b00,
    EMB_TRUE_DUAL   = 2'b01,
    EMB_PSEUDO_DUAL = 2'b10,
    EMB_FIFO        = 2'b11
  } emb_mode_e;

  // Shape codes, named by data width
  localparam logic [2:0] EMB_X1  = 3'h0;
  localparam logic [2:0] EMB_X2  = 3'h1;
  localparam logic [2:0] EMB_X4  = 3'h2;
  localparam logic [2:0] EMB_X9  = 3'h3;
  localparam logic [2:0] EMB_X18 = 3'h4;

  localparam logic [4:0] EMB_BITS_X1  = 5'h01;
  localparam logic [4:0] EMB_BITS_X2  = 5'h02;
  localparam logic [4:0] EMB_BITS_X4  = 5'h04;
  localparam logic [4:0] EMB_BITS_X9  = 5'h09;
  localparam logic [4:0] EMB_BITS_X18 = 5'h12;

  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_INIT = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;

  localparam int unsigned CTRL_OREG_A = 0;
  localparam int unsigned CTRL_OREG_B = 1;
  localparam int unsigned CTRL_MODE   = 2;
  localparam int unsigned CTRL_WA     = 4;
  localparam int unsigned CTRL_WB     = 7;
  localparam int unsigned CTRL_WLOCK  = 10;
  localparam int unsigned INIT_START  = 0;
  localparam int unsigned INIT_ZERO   = 1;
  localparam int unsigned INIT_BASE   = 16;
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned STAT_DONE   = 1;
endpackage
`default_nettype wire

// ===== hw/emb_init_loader.sv
`default_nettype none
module emb_init_loader (
  input  wire logic                               clk_i,
  input  wire logic                               sys_rst_i,
  input  wire logic                               start_i,
  input  wire logic                               zero_i,
  input  wire logic [emb_pkg::FLASH_AW-1:0]       base_i,
  output logic                                    flash_rd_o,
  output logic      [emb_pkg::FLASH_AW-1:0]       flash_addr_o,
  input  wire logic [emb_pkg::DATA_W-1:0]         flash_data_i,
  input  wire logic                               flash_ack_i,
  output logic                                    wr_o,
  output logic      [emb_pkg::ROW_AW-1:0]         wr_row_o,
  output logic      [emb_pkg::DATA_W-1:0]         wr_data_o,
  output logic                                    busy_o,
  output logic                                    done_o
);
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_ZERO = 2'b01,
    LD_REQ  = 2'b10,
    LD_WAIT = 2'b11
  } emb_ld_e;

  typedef struct packed {
    emb_ld_e                        state;
    logic [emb_pkg::ROW_AW-1:0]     row;
    logic [emb_pkg::FLASH_AW-1:0]   base_q;
    logic                           zero_q;
    logic                           rd;
    logic [emb_pkg::FLASH_AW-1:0]   faddr;
    logic                           wr;
    logic [emb_pkg::ROW_AW-1:0]     wr_row;
    logic [emb_pkg::DATA_W-1:0]     wr_data;
    logic                           busy;
    logic                           done;
  } emb_ld_s;

  localparam logic [emb_pkg::ROW_AW-1:0] LAST_ROW = 9'h1ff;

  emb_ld_s st;
  emb_ld_s next_st;

  always_comb begin
    next_st    = st;
    next_st.rd = 1'b0;
    next_st.wr = 1'b0;
    case (st.state)
      LD_IDLE: begin
        if (start_i) begin
          next_st.row    = '0;
          next_st.base_q = base_i;
          next_st.zero_q = zero_i;
          next_st.busy   = 1'b1;
          next_st.done   = 1'b0;
          next_st.state  = zero_i ? LD_ZERO : LD_REQ;
        end
      end
      LD_ZERO: begin
        // All-zero image is generated here, flash untouched
        next_st.wr      = 1'b1;
        next_st.wr_row  = st.row;
        next_st.wr_data = '0;
        if (st.row == LAST_ROW) begin
          next_st.state = LD_IDLE;
          next_st.busy  = 1'b0;
          next_st.done  = 1'b1;
        end else begin
          next_st.row = st.row + 9'h001;
        end
      end
      LD_REQ: begin
        next_st.rd    = 1'b1;
        // Same base in several blocks shares one flash image
        next_st.faddr = st.base_q + emb_pkg::FLASH_AW'(st.row);
        next_st.state = LD_WAIT;
      end
      LD_WAIT: begin
        if (flash_ack_i) begin
          next_st.wr      = 1'b1;
          next_st.wr_row  = st.row;
          next_st.wr_data = flash_data_i;
          if (st.row == LAST_ROW) begin
            next_st.state = LD_IDLE;
            next_st.busy  = 1'b0;
            next_st.done  = 1'b1;
          end else begin
            next_st.row   = st.row + 9'h001;
            next_st.state = LD_REQ;
          end
        end
      end
      default: next_st.state = LD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flash_rd_o   = st.rd;
  assign flash_addr_o = st.faddr;
  assign wr_o         = st.wr;
  assign wr_row_o     = st.wr_row;
  assign wr_data_o    = st.wr_data;
  assign busy_o       = st.busy;
  assign done_o       = st.done;

  ////////////////////////////////////////////////////////////////////////////
  a_zero_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.busy && st.zero_q |-> !st.rd) else $error("flash read during zero fill");
  a_flash_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.rd |-> st.faddr == st.base_q + emb_pkg::FLASH_AW'(st.row))
    else $error("flash address not base plus row");
  a_fetch_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.state == LD_WAIT && flash_ack_i |=> st.wr && st.wr_data == $past(flash_data_i))
    else $error("fetched flash word not written");
  c_zero_done: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    st.zero_q && $rose(st.done));
endmodule
`default_nettype wire

// ===== hw/emb_ram.sv
// Chosen here: the plain strobed port and the address map.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Single and true dual: x1, x2, x4, x9
// - Pseudo dual and FIFO also offer x18
// - Each port picks its own width
// - Word zero in lowest bits, LSB first
// - Optional preload before ports are used
// - Preload image fetched from user flash
// - All-zero preload uses no flash words
// - Equal patterns share one flash region
// - Address and write data registered at input
// - Output register optional, else direct
module emb_ram (
  input  wire logic                               clk_i,
  input  wire logic                               sys_rst_i,
  input  wire logic [emb_pkg::BUS_AW-1:0]         bus_addr_i,
  input  wire logic [emb_pkg::BUS_DW-1:0]         bus_wdata_i,
  input  wire logic                               bus_wr_i,
  input  wire logic                               bus_rd_i,
  output logic      [emb_pkg::BUS_DW-1:0]         bus_rdata_o,
  input  wire logic                               a_en_i,
  input  wire logic                               a_we_i,
  input  wire logic [emb_pkg::ADDR_W-1:0]         a_addr_i,
  input  wire logic [emb_pkg::DATA_W-1:0]         a_wdata_i,
  output logic      [emb_pkg::DATA_W-1:0]         a_rdata_o,
  output logic                                    a_rvalid_o,
  input  wire logic                               b_en_i,
  input  wire logic                               b_we_i,
  input  wire logic [emb_pkg::ADDR_W-1:0]         b_addr_i,
  input  wire logic [emb_pkg::DATA_W-1:0]         b_wdata_i,
  output logic      [emb_pkg::DATA_W-1:0]         b_rdata_o,
  output logic                                    b_rvalid_o,
  output logic                                    flash_rd_o,
  output logic      [emb_pkg::FLASH_AW-1:0]       flash_addr_o,
  input  wire logic [emb_pkg::DATA_W-1:0]         flash_data_i,
  input  wire logic                               flash_ack_i,
  output logic                                    init_busy_o
);
  typedef struct packed {
    logic [1:0]                                   oreg;
    emb_pkg::emb_mode_e                           mode;
    logic [1:0][emb_pkg::WCODE_W-1:0]             wcode;
    logic                                         wlock;
    logic                                         zero;
    logic [emb_pkg::FLASH_AW-1:0]                 base;
    logic                                         start;
    logic [1:0]                                   cap_rd;
    logic [1:0]                                   cap_we;
    logic [1:0][emb_pkg::ADDR_W-1:0]              cap_addr;
    logic [1:0][emb_pkg::DATA_W-1:0]              cap_wd;
    logic [1:0][emb_pkg::WCODE_W-1:0]             cap_w;
    logic [1:0][emb_pkg::DATA_W-1:0]              pipe;
    logic [1:0]                                   pipe_v;
    logic [1:0][emb_pkg::DATA_W-1:0]              rdata;
    logic [1:0]                                   rvalid;
    logic [emb_pkg::BUS_DW-1:0]                   bus_rdata;
  } emb_ram_s;

  // All fields clear: single port, x1 shapes, no output register
  localparam emb_ram_s EMB_RAM_RST = '0;

  default clocking emb_cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Out-of-range codes fold to x18; x18 only in the split-port modes
  function automatic logic [2:0] eff_width(input logic [2:0] code,
                                           input emb_pkg::emb_mode_e mode);
    logic [2:0] c;
    c = (code > emb_pkg::EMB_X18) ? emb_pkg::EMB_X18 : code;
    if (c == emb_pkg::EMB_X18 &&
        (mode == emb_pkg::EMB_SINGLE || mode == emb_pkg::EMB_TRUE_DUAL)) begin
      c = emb_pkg::EMB_X9;
    end
    return c;
  endfunction

  function automatic logic [4:0] width_bits(input logic [2:0] code);
    logic [4:0] n;
    case (code)
      emb_pkg::EMB_X1: n = emb_pkg::EMB_BITS_X1;
      emb_pkg::EMB_X2: n = emb_pkg::EMB_BITS_X2;
      emb_pkg::EMB_X4: n = emb_pkg::EMB_BITS_X4;
      emb_pkg::EMB_X9: n = emb_pkg::EMB_BITS_X9;
      default:         n = emb_pkg::EMB_BITS_X18;
    endcase
    return n;
  endfunction

  // First storage bit of a word: address times width; x9 and x18 wrap at the depth, x2 and x4 at 8192 bits
  function automatic logic [13:0] bit_base(input logic [12:0] addr,
                                           input logic [2:0] code);
    logic [13:0] b;
    case (code)
      emb_pkg::EMB_X1: b = {1'b0, addr};
      emb_pkg::EMB_X2: b = {1'b0, addr[11:0], 1'b0};
      emb_pkg::EMB_X4: b = {1'b0, addr[10:0], 2'b00};
      emb_pkg::EMB_X9: b = {1'b0, addr[9:0], 3'b000} + {4'h0, addr[9:0]};
      default:         b = {1'b0, addr[8:0], 4'h0} + {4'h0, addr[8:0], 1'b0};
    endcase
    return b;
  endfunction

  // Which port may read or write in each mode
  function automatic logic port_ok(input int p, input emb_pkg::emb_mode_e mode,
                                   input logic wr);
    logic ok;
    case (mode)
      emb_pkg::EMB_SINGLE:    ok = (p == 0);
      emb_pkg::EMB_TRUE_DUAL: ok = 1'b1;
      default:                ok = wr ? (p == 0) : (p == 1);
    endcase
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  emb_ram_s st;
  emb_ram_s next_st;

  logic                                   mem [0:emb_pkg::BITS-1];
  logic [1:0]                             en_in;
  logic [1:0]                             we_in;
  logic [1:0][emb_pkg::ADDR_W-1:0]        addr_in;
  logic [1:0][emb_pkg::DATA_W-1:0]        wd_in;
  logic [1:0][emb_pkg::DATA_W-1:0]        arr_rd;
  logic [1:0][emb_pkg::IDX_W-1:0]         acc_base;
  logic [1:0][4:0]                        acc_bits;
  logic                                   ld_wr;
  logic [emb_pkg::ROW_AW-1:0]             ld_row;
  logic [emb_pkg::DATA_W-1:0]             ld_data;
  logic                                   ld_busy;
  logic                                   ld_done;
  logic [emb_pkg::IDX_W-1:0]              ld_base;

  assign en_in   = {b_en_i, a_en_i};
  assign we_in   = {b_we_i, a_we_i};
  assign addr_in = {b_addr_i, a_addr_i};
  assign wd_in   = {b_wdata_i, a_wdata_i};
  assign ld_base = bit_base(13'(ld_row), emb_pkg::EMB_X18);

  emb_init_loader u_loader (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .start_i      (st.start),
    .zero_i       (st.zero),
    .base_i       (st.base),
    .flash_rd_o   (flash_rd_o),
    .flash_addr_o (flash_addr_o),
    .flash_data_i (flash_data_i),
    .flash_ack_i  (flash_ack_i),
    .wr_o         (ld_wr),
    .wr_row_o     (ld_row),
    .wr_data_o    (ld_data),
    .busy_o       (ld_busy),
    .done_o       (ld_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Array read from the registered address, same mapping for both widths
  for (genvar p = 0; p < 2; p++) begin : g_port
    assign acc_base[p] = bit_base(st.cap_addr[p], st.cap_w[p]);
    assign acc_bits[p] = width_bits(st.cap_w[p]);
    for (genvar i = 0; i < emb_pkg::DATA_W; i++) begin : g_bit
      logic [emb_pkg::IDX_W-1:0] idx;
      assign idx = acc_base[p] + emb_pkg::IDX_W'(i);
      assign arr_rd[p][i] = (5'(i) < acc_bits[p] && idx < emb_pkg::IDX_W'(emb_pkg::BITS))
                            ? mem[idx] : 1'b0;
    end
  end

  // Loader writes first, port B last: B wins a true dual-port collision
  always_ff @(posedge clk_i) begin
    if (ld_wr) begin
      for (int i = 0; i < emb_pkg::DATA_W; i++) begin
        mem[ld_base + emb_pkg::IDX_W'(i)] <= ld_data[i];
      end
    end
    for (int p = 0; p < 2; p++) begin
      if (st.cap_we[p]) begin
        for (int i = 0; i < emb_pkg::DATA_W; i++) begin
          if (5'(i) < acc_bits[p] &&
              acc_base[p] + emb_pkg::IDX_W'(i) < emb_pkg::IDX_W'(emb_pkg::BITS)) begin
            mem[acc_base[p] + emb_pkg::IDX_W'(i)] <= st.cap_wd[p][i];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st           = st;
    next_st.start     = 1'b0;
    next_st.bus_rdata = '0;
    if (bus_wr_i) begin
      if (bus_addr_i == emb_pkg::OFS_CTRL) begin
        next_st.oreg[0]  = bus_wdata_i[emb_pkg::CTRL_OREG_A];
        next_st.oreg[1]  = bus_wdata_i[emb_pkg::CTRL_OREG_B];
        next_st.mode     = emb_pkg::emb_mode_e'(bus_wdata_i[emb_pkg::CTRL_MODE +: 2]);
        next_st.wcode[0] = bus_wdata_i[emb_pkg::CTRL_WA +: emb_pkg::WCODE_W];
        next_st.wcode[1] = bus_wdata_i[emb_pkg::CTRL_WB +: emb_pkg::WCODE_W];
        next_st.wlock    = bus_wdata_i[emb_pkg::CTRL_WLOCK];
      end else if (bus_addr_i == emb_pkg::OFS_INIT) begin
        next_st.zero  = bus_wdata_i[emb_pkg::INIT_ZERO];
        next_st.base  = bus_wdata_i[emb_pkg::INIT_BASE +: emb_pkg::FLASH_AW];
        next_st.start = bus_wdata_i[emb_pkg::INIT_START] & ~ld_busy;
      end
    end
    if (bus_rd_i) begin
      if (bus_addr_i == emb_pkg::OFS_CTRL) begin
        next_st.bus_rdata[emb_pkg::CTRL_OREG_A]                   = st.oreg[0];
        next_st.bus_rdata[emb_pkg::CTRL_OREG_B]                   = st.oreg[1];
        next_st.bus_rdata[emb_pkg::CTRL_MODE +: 2]                = st.mode;
        next_st.bus_rdata[emb_pkg::CTRL_WA +: emb_pkg::WCODE_W]   = st.wcode[0];
        next_st.bus_rdata[emb_pkg::CTRL_WB +: emb_pkg::WCODE_W]   = st.wcode[1];
        next_st.bus_rdata[emb_pkg::CTRL_WLOCK]                    = st.wlock;
      end else if (bus_addr_i == emb_pkg::OFS_INIT) begin
        next_st.bus_rdata[emb_pkg::INIT_ZERO]                     = st.zero;
        next_st.bus_rdata[emb_pkg::INIT_BASE +: emb_pkg::FLASH_AW] = st.base;
      end else if (bus_addr_i == emb_pkg::OFS_STAT) begin
        next_st.bus_rdata[emb_pkg::STAT_BUSY] = ld_busy;
        next_st.bus_rdata[emb_pkg::STAT_DONE] = ld_done;
      end
    end
    for (int p = 0; p < 2; p++) begin
      // Input registers; ports shut out while preload runs
      next_st.cap_addr[p] = addr_in[p];
      next_st.cap_wd[p]   = wd_in[p];
      next_st.cap_w[p]    = eff_width(st.wcode[p], st.mode);
      next_st.cap_rd[p]   = en_in[p] & ~we_in[p] & ~ld_busy &
                            port_ok(p, st.mode, 1'b0);
      // Write lock turns the block into a ROM
      next_st.cap_we[p]   = en_in[p] & we_in[p] & ~ld_busy & ~st.wlock &
                            port_ok(p, st.mode, 1'b1);
      next_st.pipe_v[p]   = st.cap_rd[p];
      if (st.cap_rd[p]) begin
        next_st.pipe[p] = arr_rd[p];
      end
      if (st.oreg[p]) begin
        next_st.rvalid[p] = st.pipe_v[p];
        if (st.pipe_v[p]) begin
          next_st.rdata[p] = st.pipe[p];
        end
      end else begin
        next_st.rvalid[p] = st.cap_rd[p];
        if (st.cap_rd[p]) begin
          next_st.rdata[p] = arr_rd[p];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= EMB_RAM_RST;
    end else begin
      st <= next_st;
    end
  end

  assign bus_rdata_o = st.bus_rdata;
  assign a_rdata_o   = st.rdata[0];
  assign a_rvalid_o  = st.rvalid[0];
  assign b_rdata_o   = st.rdata[1];
  assign b_rvalid_o  = st.rvalid[1];
  assign init_busy_o = ld_busy;

  ////////////////////////////////////////////////////////////////////////////
  a_capture_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    a_en_i |=> st.cap_addr[0] == $past(a_addr_i) && st.cap_wd[0] == $past(a_wdata_i))
    else $error("port input not registered");
  a_bypass_lat: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.cap_rd[0] && !st.oreg[0] |=> a_rvalid_o && a_rdata_o == $past(arr_rd[0]))
    else $error("bypass read data not presented next cycle");
  a_oreg_lat: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.cap_rd[1] && st.oreg[1] ##1 st.oreg[1] |=> b_rvalid_o && b_rdata_o == $past(arr_rd[1], 2))
    else $error("registered read data late or wrong");
  a_oreg_gap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.cap_rd[1] && st.oreg[1] && !st.pipe_v[1] |=> !b_rvalid_o)
    else $error("registered read came without extra cycle");
  a_width_clamp: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (st.cap_rd[0] || st.cap_we[0]) &&
    ($past(st.mode) == emb_pkg::EMB_SINGLE || $past(st.mode) == emb_pkg::EMB_TRUE_DUAL)
    |-> st.cap_w[0] != emb_pkg::EMB_X18) else $error("x18 shape in single or true dual");
  a_pdp_wide: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.cap_rd[1] && $past(st.mode) == emb_pkg::EMB_PSEUDO_DUAL &&
    $past(st.wcode[1]) == emb_pkg::EMB_X18 && $past(st.wcode[0]) == emb_pkg::EMB_X1
    |-> st.cap_w[1] == emb_pkg::EMB_X18) else $error("port width not independent");
  a_bit_map: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.cap_we[0] && !st.cap_we[1] && st.cap_w[0] == emb_pkg::EMB_X1
    |=> mem[$past(st.cap_addr[0])] == $past(st.cap_wd[0][0]))
    else $error("x1 word not at its bit");
  a_init_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ld_busy |=> st.cap_we == 2'b00 && st.cap_rd == 2'b00)
    else $error("port access during preload");
  a_rom_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st.wlock |=> st.cap_we == 2'b00) else $error("write passed the lock");

  // Port gating and port B reads checked; bit positions worked out here apart from bit_base
  a_single_b_off: assert property (
    st.mode == emb_pkg::EMB_SINGLE |=> st.cap_rd[1] == 1'b0 && st.cap_we[1] == 1'b0)
    else $error("port B active in single port mode");

  a_split_dir: assert property (
    st.mode == emb_pkg::EMB_PSEUDO_DUAL || st.mode == emb_pkg::EMB_FIFO
    |=> st.cap_we[1] == 1'b0 && st.cap_rd[0] == 1'b0)
    else $error("wrong port direction in split-port mode");

  a_bypass_b: assert property (
    st.cap_rd[1] && !st.oreg[1] |=> b_rvalid_o && b_rdata_o == $past(arr_rd[1]))
    else $error("port B bypass read late or wrong");

  a_x9_map: assert property (
    st.cap_we[0] && !st.cap_we[1] && st.cap_w[0] == emb_pkg::EMB_X9
    |=> mem[$past(st.cap_addr[0][9:0]) * int'(emb_pkg::EMB_BITS_X9)] == $past(st.cap_wd[0][0]))
    else $error("x9 word low bit misplaced");

  a_x18_map: assert property (
    st.cap_we[0] && !st.cap_we[1] && st.cap_w[0] == emb_pkg::EMB_X18
    |=> mem[$past(st.cap_addr[0][8:0]) * int'(emb_pkg::DATA_W) + int'(emb_pkg::DATA_W) - 1]
        == $past(st.cap_wd[0][emb_pkg::DATA_W-1]))
    else $error("x18 word top bit misplaced");

  a_preload_map: assert property (
    ld_wr |=> mem[$past(ld_row) * int'(emb_pkg::DATA_W)] == $past(ld_data[0]))
    else $error("preloaded row misplaced");

  a_rvalid_only: assert property (
    !st.cap_rd[1] && !st.pipe_v[1] |=> !b_rvalid_o)
    else $error("port B read valid without a read");

  c_single_read: cover property (st.mode == emb_pkg::EMB_SINGLE && a_rvalid_o);
  c_oreg_read: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    st.oreg[1] && b_rvalid_o);
  c_pdp_write: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    st.mode == emb_pkg::EMB_PSEUDO_DUAL && st.cap_we[0]);
  c_flash_init: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    !st.zero && $fell(ld_busy));
endmodule
`default_nettype wire

// ===== hw/emb_ram_dummy_guard.sv
`default_nettype none
`default_nettype wire

// ===== tb/emb_flash_model.sv
`default_nettype none
module emb_flash_model (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        rd_i,
  input  wire logic [11:0] addr_i,
  output logic      [17:0] data_o,
  output logic             ack_o
);
  logic [11:0] adr;
  logic [1:0]  cnt;
  logic        busy;
  // Odd addresses answer slowly; data churns outside the ack cycle
  always_ff @(posedge clk_i) begin
    ack_o  <= 1'b0;
    data_o <= ~data_o;
    if (sys_rst_i) begin
      busy   <= 1'b0;
      data_o <= 18'h0;
    end else if (rd_i && !busy) begin
      busy <= 1'b1;
      adr  <= addr_i;
      cnt  <= addr_i[0] ? 2'h3 : 2'h0;
    end else if (busy && cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end else if (busy) begin
      busy   <= 1'b0;
      ack_o  <= 1'b1;
      data_o <= {adr[5:0] ^ 6'h2a, adr};
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, bus_wr_i = 1'b0, bus_rd_i = 1'b0;
  logic        a_en_i = 1'b0, a_we_i = 1'b0, b_en_i = 1'b0;
  logic        a_rvalid_o, b_rvalid_o, flash_rd_o, flash_ack_i, init_busy_o;
  logic [3:0]  bus_addr_i = 4'h0;
  logic [31:0] bus_wdata_i = 32'h0, bus_rdata_o;
  logic [12:0] a_addr_i = 13'h0, b_addr_i = 13'h0;
  logic [17:0] a_wdata_i = 18'h0, a_rdata_o, b_rdata_o, flash_data_i;
  logic [11:0] flash_addr_o;
  int          err_total = 0, n_tests = 0, cyc = 0, nrd = 0;

  emb_ram emb_ram_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
    .bus_rdata_o(bus_rdata_o), .a_en_i(a_en_i), .a_we_i(a_we_i), .a_addr_i(a_addr_i),
    .a_wdata_i(a_wdata_i), .a_rdata_o(a_rdata_o), .a_rvalid_o(a_rvalid_o), .b_en_i(b_en_i),
    .b_we_i(1'b0),
    .b_addr_i(b_addr_i), .b_wdata_i(18'h0), .b_rdata_o(b_rdata_o), .b_rvalid_o(b_rvalid_o),
    .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o), .flash_data_i(flash_data_i),
    .flash_ack_i(flash_ack_i), .init_busy_o(init_busy_o));

  emb_flash_model emb_flash_model_inst (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .rd_i(flash_rd_o), .addr_i(flash_addr_o),
    .data_o(flash_data_i), .ack_o(flash_ack_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // Ceiling well above the flash preload, which dominates the run
  always @(posedge clk_i) begin
    cyc++;
    if (flash_rd_o === 1'b1) nrd++;
    if (cyc == 8000) begin
      err_total++;
      final_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] ctl(input logic ob, input logic [1:0] m,
                                      input logic [2:0] wa, input logic [2:0] wb,
                                      input logic lk);
    return {21'h0, lk, wb, wa, m, ob, 1'b0};
  endfunction

  function automatic logic [17:0] pat(input logic [11:0] a);
    return {a[5:0] ^ 6'h2a, a};
  endfunction

  task automatic bw(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    bus_wr_i    <= 1'b1;
    bus_addr_i  <= ad;
    bus_wdata_i <= d;
    @(posedge clk_i);
    bus_wr_i    <= 1'b0;
  endtask

  task automatic br(input logic [3:0] ad, input logic [31:0] exp);
    @(posedge clk_i);
    bus_rd_i   <= 1'b1;
    bus_addr_i <= ad;
    @(posedge clk_i);
    bus_rd_i   <= 1'b0;
    @(posedge clk_i);
    chk(bus_rdata_o, exp);
  endtask

  task automatic wr_a(input logic [12:0] ad, input logic [17:0] d);
    @(posedge clk_i);
    a_en_i    <= 1'b1;
    a_we_i    <= 1'b1;
    a_addr_i  <= ad;
    a_wdata_i <= d;
    @(posedge clk_i);
    a_en_i    <= 1'b0;
    a_we_i    <= 1'b0;
  endtask

  // Latency counted in edges after the taking edge
  task automatic rd_b(input logic [12:0] ad, input logic [17:0] exp, input int lat,
                      input logic pa = 1'b0);
    int n;
    n = 0;
    @(posedge clk_i);
    a_en_i   <= pa;
    b_en_i   <= !pa;
    a_addr_i <= ad;
    b_addr_i <= ad;
    @(posedge clk_i);
    a_en_i   <= 1'b0;
    b_en_i   <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((pa ? a_rvalid_o : b_rvalid_o) !== 1'b1 && n < 6);
    chk(32'(n), 32'(lat));
    chk({14'h0, pa ? a_rdata_o : b_rdata_o}, {14'h0, exp});
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (init_busy_o !== 1'b1 && k < 6);
    while (init_busy_o !== 1'b0 && k < 6000) begin
      @(posedge clk_i);
      k++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_widths;
    int wid[4] = '{1, 2, 4, 9};
    wr_a(13'd100, 18'h1);
    rd_b(13'd100, 18'h1, 2, 1'b1);
    rd_b(13'd100, 18'h0, 6);
    bw(emb_pkg::OFS_CTRL, ctl(1'b0, 2'h1, emb_pkg::EMB_X9, emb_pkg::EMB_X1, 1'b0));
    wr_a(13'h7, 18'h001a5);
    rd_b(13'd63, 18'h1, 2);
    rd_b(13'd64, 18'h0, 2);
    bw(emb_pkg::OFS_CTRL, ctl(1'b0, 2'h2, emb_pkg::EMB_X18, emb_pkg::EMB_X18, 1'b0));
    wr_a(13'h2, 18'h3a5c6);
    rd_b(13'h2, 18'h3a5c6, 2);
    for (int c = 0; c < 4; c++) begin
      bw(emb_pkg::OFS_CTRL, ctl(1'b0, 2'h2, emb_pkg::EMB_X18, 3'(c), 1'b0));
      rd_b(13'(36 / wid[c]), 18'h3a5c6 & ((18'h1 << wid[c]) - 18'h1), 2);
    end
    bw(emb_pkg::OFS_CTRL, ctl(1'b1, 2'h2, emb_pkg::EMB_X18, emb_pkg::EMB_X18, 1'b0));
    rd_b(13'h2, 18'h3a5c6, 3);
  endtask

  task automatic t_preload(input logic zero, input logic [11:0] base, input int reads);
    int n0;
    bw(emb_pkg::OFS_CTRL, ctl(1'b0, 2'h2, emb_pkg::EMB_X18, emb_pkg::EMB_X18, 1'b0));
    n0 = nrd;
    bw(emb_pkg::OFS_INIT, {4'h0, base, 14'h0, zero, 1'b1});
    wait_idle;
    chk(32'(nrd - n0), 32'(reads));
    br(emb_pkg::OFS_STAT, 32'h2);
    rd_b(13'h0, zero ? 18'h0 : pat(base), 2);
    rd_b(13'd511, zero ? 18'h0 : pat(base + 12'd511), 2);
  endtask

  task automatic t_rom;
    bw(emb_pkg::OFS_CTRL, ctl(1'b0, 2'h2, emb_pkg::EMB_X18, emb_pkg::EMB_X18, 1'b1));
    wr_a(13'h0, 18'h0);
    rd_b(13'h0, pat(12'h100), 2);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_widths;
    t_preload(1'b1, 12'h0, 0);
    t_preload(1'b0, 12'h100, 512);
    t_preload(1'b0, 12'h100, 512); // Same base gives the same image
    t_rom;
    final_report;
  end
endmodule
`default_nettype wire
